// ==== logic/frge_pkg.sv ====
// Purpose: shared constants for the fault reaction and gate enable block
// Assumes: system clock of 250 MHz, reference clock of 1 MHz
// Notes: reaction codes are the three-bit values written by software
package frge_pkg;

  // clock and reference timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int REF_PERIOD_NS = 1000;
  localparam int REF_CYCLES = (REF_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  // oscillator window: low limit on a whole period, high on a half
  localparam int OSC_CNT_W = 9;
  localparam logic [8:0] OSC_CNT_MAX = 9'h1FF;
  localparam logic [8:0] LF_MIN_CYCLES = 9'(REF_CYCLES * 4 / 5);
  localparam logic [8:0] HF_MAX_HALF = 9'((REF_CYCLES / 2) * 6 / 5);

  // alarm filter times, one per filter select code
  localparam int FILT_W = 11;
  localparam int FILT0_NS = 1000;
  localparam int FILT1_NS = 2000;
  localparam int FILT2_NS = 4000;
  localparam int FILT3_NS = 8000;
  localparam logic [10:0] FILT0_CYC = 11'((FILT0_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [10:0] FILT1_CYC = 11'((FILT1_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [10:0] FILT2_CYC = 11'((FILT2_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [10:0] FILT3_CYC = 11'((FILT3_NS * 1000) / CLK_PERIOD_PS);

  // short-circuit reaction codes
  localparam logic [2:0] SC_FLAG_ONLY = 3'h0;
  localparam logic [2:0] SC_PHASE_LIVE = 3'h1;
  localparam logic [2:0] SC_PHASE_HOLD = 3'h2;
  localparam logic [2:0] SC_ALL_LIVE = 3'h3;
  localparam logic [2:0] SC_ALL_HOLD = 3'h4;
  localparam logic [2:0] SC_ALL_CP_LIVE = 3'h5;
  localparam logic [2:0] SC_ALL_CP_HOLD = 3'h6;

  // frequency-fault reaction codes; bit 2 switches detection off
  localparam logic [2:0] FR_DIAG_ONLY = 3'h0;
  localparam logic [2:0] FR_GATE_LIVE = 3'h1;
  localparam logic [2:0] FR_GATE_CP_LIVE = 3'h2;
  localparam logic [2:0] FR_ALL_HOLD = 3'h3;
  localparam int FR_OFF_BIT = 2;
  localparam logic [2:0] FR_MODE_RST = 3'h0;

endpackage

// ==== logic/frge_top.sv ====
// Purpose: short-circuit and frequency fault reactions, alarm filtering
//   and the four gate enables of a three-phase pre-driver
// Assumes: comparator and pin inputs are asynchronous to clk_sys;
//   power_good, permits and software controls are on clk_sys
// Notes: no software-reached registers; controls are plain ports
// Notes on behaviour
// - code 001 stops the faulty phase, 011 stops all phases while shorted.
// - code 010 stops the faulty phase, 100 stops all phases.
// - codes 010, 100, 110 hold outputs off and diag low until flag clear.
// - code 101 holds diag low and stops pre-drivers and charge pump.
// - low-frequency check restarts each reference period, flags at rising edge.
// - high-frequency fault flagged when count still high at reference fall.
// - five frequency reaction modes chosen by a three-bit field.
// - new frequency mode applies only once faults and both flags are clear.
// - mode field top bit set disables frequency detection.
// - frequency code 011 holds outputs off and diag low until flag clear.
// - frequency codes 000-010 resume outputs after fault, diag stays low.
// - flag clear restores operation and diag high; refused while fault stays.
// - either alarm low disables every gate enable.
// - both alarms high leaves each gate to its own controls.
// - each alarm passes a digital filter with selectable time.
// - an alarm low enables short-circuit detection.
// - a phase gate needs its own permit, power_good and both alarms; its own short, all-phase short and frequency reactions stop it.
`timescale 1ns/1ps
module frge_top (
  input wire logic clk_sys, // system clock, 250 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic alarm_in_a, // alarm pin a, active low
  input wire logic alarm_in_b, // alarm pin b, active low
  input wire logic [1:0] alarm_filter_sel, // alarm filter time select
  input wire logic power_good, // internal supply good, high when ok
  input wire logic gate_permit_u, // u phase permit
  input wire logic gate_permit_v, // v phase permit
  input wire logic gate_permit_w, // w phase permit
  input wire logic gate_permit_r, // relay permit
  input wire logic [2:0] short_detect, // per-phase short comparators {w,v,u}
  input wire logic [2:0] short_fault_reaction, // short reaction code
  input wire logic short_flag_clear, // pulse, clears short flags
  input wire logic ref_clock_1mhz, // 1 MHz reference clock
  input wire logic [2:0] freq_fault_reaction, // frequency reaction code
  input wire logic freq_flag_clear, // pulse, clears frequency flags
  output logic gate_en_u, // u phase gate enable
  output logic gate_en_v, // v phase gate enable
  output logic gate_en_w, // w phase gate enable
  output logic gate_en_r, // relay gate enable
  output logic charge_pump_off, // request to stop the charge pump
  output logic diag_ok_n_out, // diagnostic level, low on any fault
  output logic short_detect_en, // short detection armed
  output logic [2:0] short_flag, // latched short flags {w,v,u}
  output logic low_freq_flag, // latched low-frequency flag
  output logic high_freq_flag, // latched high-frequency flag
  output logic [2:0] freq_mode // reaction mode in force
);

  logic [1:0] alarm_s1_q;
  logic [1:0] alarm_s2_q;
  logic [2:0] short_s1_q;
  logic [2:0] short_s2_q;
  logic ref_s1_q;
  logic ref_s2_q;
  logic ref_s3_q;
  logic [1:0] alarm_filt_q;
  logic [1:0] alarm_settled_q;
  logic [10:0] filt_target;
  logic sc_enable_q;
  logic [2:0] sc_flag_q;
  logic [2:0] sc_live;
  logic [2:0] sc_phase_off;
  logic sc_all_off;
  logic sc_cp_off;
  logic [8:0] osc_cnt_q;
  logic ref_armed_q;
  logic ref_rise;
  logic ref_fall;
  logic lf_active_q;
  logic hf_active_q;
  logic lf_flag_q;
  logic hf_flag_q;
  logic [2:0] freq_mode_q;
  logic fq_live;
  logic fq_flag_any;
  logic fq_gate_off;
  logic fq_cp_off;
  logic [3:0] permit;
  logic [3:0] gate_off;
  logic [3:0] gate_q;
  logic gates_ok;
  logic cp_off_q;
  logic diag_q;

  // pin synchronisers; alarms idle high so nothing looks low at reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alarm_s1_q <= 2'h3;
      alarm_s2_q <= 2'h3;
      short_s1_q <= 3'h0;
      short_s2_q <= 3'h0;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      alarm_s1_q <= {alarm_in_b, alarm_in_a};
      alarm_s2_q <= alarm_s1_q;
      short_s1_q <= short_detect;
      short_s2_q <= short_s1_q;
      ref_s1_q <= ref_clock_1mhz;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  // filter time in cycles from the software select
  always_comb begin
    unique case (alarm_filter_sel)
      2'h0: filt_target = frge_pkg::FILT0_CYC;
      2'h1: filt_target = frge_pkg::FILT1_CYC;
      2'h2: filt_target = frge_pkg::FILT2_CYC;
      2'h3: filt_target = frge_pkg::FILT3_CYC;
    endcase
  end

  // one filter per alarm; output starts low so gates stay off
  // until the pin has been seen stable for a full filter time
  for (genvar i = 0; i < 2; i++) begin : g_alarm
    logic [10:0] cnt_q;
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        cnt_q <= 11'h000;
        alarm_filt_q[i] <= 1'b0;
        alarm_settled_q[i] <= 1'b0;
      end else if (alarm_s2_q[i] == alarm_filt_q[i]) begin
        cnt_q <= 11'h000;
        alarm_settled_q[i] <= 1'b1;
      end else if (cnt_q + 11'h001 >= filt_target) begin
        cnt_q <= 11'h000;
        alarm_filt_q[i] <= alarm_s2_q[i];
        alarm_settled_q[i] <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end

  // alarm low arms shorts
  // stays armed until reset; a pin still settling does not count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sc_enable_q <= 1'b0;
    end else if (|(alarm_settled_q & ~alarm_filt_q)) begin
      sc_enable_q <= 1'b1;
    end
  end

  assign sc_live = sc_enable_q ? short_s2_q : 3'h0;

  // short flags: a new detection wins over a clear in the same cycle,
  // and a flag whose short is still present cannot be cleared
  for (genvar i = 0; i < 3; i++) begin : g_short
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        sc_flag_q[i] <= 1'b0;
      end else if (sc_live[i]) begin
        sc_flag_q[i] <= 1'b1;
      end else if (short_flag_clear) begin
        sc_flag_q[i] <= 1'b0;
      end
    end
    assign sc_phase_off[i] =
      (short_fault_reaction == frge_pkg::SC_PHASE_LIVE && sc_live[i]) ||
      (short_fault_reaction == frge_pkg::SC_PHASE_HOLD && sc_flag_q[i]);
  end

  // all-phase reactions; codes 000 and 111 only flag and pull diag low
  always_comb begin
    sc_all_off = 1'b0;
    sc_cp_off = 1'b0;
    unique case (short_fault_reaction)
      frge_pkg::SC_ALL_LIVE: sc_all_off = |sc_live;
      frge_pkg::SC_ALL_HOLD: sc_all_off = |sc_flag_q;
      frge_pkg::SC_ALL_CP_LIVE: begin
        sc_all_off = |sc_live;
        sc_cp_off = |sc_live;
      end
      frge_pkg::SC_ALL_CP_HOLD: begin
        sc_all_off = |sc_flag_q;
        sc_cp_off = |sc_flag_q;
      end
      default: begin
        sc_all_off = 1'b0;
        sc_cp_off = 1'b0;
      end
    endcase
  end

  assign ref_rise = ref_s2_q & ~ref_s3_q;
  assign ref_fall = ~ref_s2_q & ref_s3_q;

  // restart every period
  // oscillator cycles since the last reference rise; saturates so a
  // stalled reference cannot wrap into a false pass
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_cnt_q <= 9'h000;
      ref_armed_q <= 1'b0;
    end else if (ref_rise) begin
      osc_cnt_q <= 9'h000;
      ref_armed_q <= 1'b1;
    end else if (osc_cnt_q != frge_pkg::OSC_CNT_MAX) begin
      osc_cnt_q <= osc_cnt_q + 9'h001;
    end
  end

  // live fault state, judged at the reference edges
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lf_active_q <= 1'b0;
      hf_active_q <= 1'b0;
    end else if (freq_mode_q[frge_pkg::FR_OFF_BIT]) begin
      lf_active_q <= 1'b0;
      hf_active_q <= 1'b0;
    end else begin
      if (ref_rise && ref_armed_q) begin
        lf_active_q <= osc_cnt_q < frge_pkg::LF_MIN_CYCLES;
      end
      if (ref_fall && ref_armed_q) begin
        hf_active_q <= osc_cnt_q > frge_pkg::HF_MAX_HALF;
      end
    end
  end

  // clear refused while faulty
  // the fault sets the flag every cycle it lasts, so set beats clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lf_flag_q <= 1'b0;
      hf_flag_q <= 1'b0;
    end else begin
      // a judgment landing on the edge that switches detection off is dropped
      if (lf_active_q && !freq_mode_q[frge_pkg::FR_OFF_BIT]) begin
        lf_flag_q <= 1'b1;
      end else if (freq_flag_clear) begin
        lf_flag_q <= 1'b0;
      end
      if (hf_active_q && !freq_mode_q[frge_pkg::FR_OFF_BIT]) begin
        hf_flag_q <= 1'b1;
      end else if (freq_flag_clear) begin
        hf_flag_q <= 1'b0;
      end
    end
  end

  assign fq_live = lf_active_q | hf_active_q;
  assign fq_flag_any = lf_flag_q | hf_flag_q;

  // mode change deferred
  // a mode swap mid-fault could release held outputs unseen
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      freq_mode_q <= frge_pkg::FR_MODE_RST;
    end else if (!fq_live && !fq_flag_any) begin
      freq_mode_q <= freq_fault_reaction;
    end
  end

  always_comb begin
    fq_gate_off = 1'b0;
    fq_cp_off = 1'b0;
    unique case (freq_mode_q)
      frge_pkg::FR_GATE_LIVE: fq_gate_off = fq_live;
      frge_pkg::FR_GATE_CP_LIVE: begin
        fq_gate_off = fq_live;
        fq_cp_off = fq_live;
      end
      frge_pkg::FR_ALL_HOLD: begin
        fq_gate_off = fq_live | fq_flag_any;
        fq_cp_off = fq_live | fq_flag_any;
      end
      default: begin
        fq_gate_off = 1'b0;
        fq_cp_off = 1'b0;
      end
    endcase
  end

  assign permit = {gate_permit_r, gate_permit_w, gate_permit_v,
    gate_permit_u};
  assign gate_off = {fq_gate_off,
    sc_phase_off | {3{sc_all_off | fq_gate_off}}};
  assign gates_ok = power_good & alarm_filt_q[0] & alarm_filt_q[1];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gate_q <= 4'h0;
    end else begin
      gate_q <= {4{gates_ok}} & permit & ~gate_off;
    end
  end

  // charge pump request and diagnostic level
  // diag high after clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cp_off_q <= 1'b0;
      diag_q <= 1'b0;
    end else begin
      cp_off_q <= sc_cp_off | fq_cp_off;
      diag_q <= ~(|sc_flag_q | fq_flag_any);
    end
  end

  assign gate_en_u = gate_q[0];
  assign gate_en_v = gate_q[1];
  assign gate_en_w = gate_q[2];
  assign gate_en_r = gate_q[3];
  assign charge_pump_off = cp_off_q;
  assign diag_ok_n_out = diag_q;
  assign short_detect_en = sc_enable_q;
  assign short_flag = sc_flag_q;
  assign low_freq_flag = lf_flag_q;
  assign high_freq_flag = hf_flag_q;
  assign freq_mode = freq_mode_q;

endmodule

// ==== tb/frge_top_sva.sv ====
// Purpose: port checker for the fault reaction and gate enable block
// Assumes: one clk_sys domain, rst asynchronous and active high
// Notes: alarm bound takes the longest filter time plus the sync stages
`timescale 1ns/1ps
module frge_top_sva (
  input logic clk_sys,
  input logic rst,
  input logic alarm_in_a,
  input logic alarm_in_b,
  input logic power_good,
  input logic gate_permit_u,
  input logic [2:0] short_detect,
  input logic [2:0] short_fault_reaction,
  input logic gate_en_u,
  input logic gate_en_v,
  input logic gate_en_r,
  input logic charge_pump_off,
  input logic diag_ok_n_out,
  input logic short_detect_en,
  input logic [2:0] short_flag,
  input logic low_freq_flag,
  input logic high_freq_flag,
  input logic [2:0] freq_mode
);
  int unsigned low_cnt_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // cycles with a pin low; saturates so it cannot wrap to zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) low_cnt_q <= 0;
    else if (alarm_in_a && alarm_in_b) low_cnt_q <= 0;
    else if (low_cnt_q < 3000) low_cnt_q <= low_cnt_q + 1;
  end
  alarm_off_a: assert property (
    low_cnt_q > 2004 |-> !gate_en_u && !gate_en_v && !gate_en_r)
    else $error("gate on while alarm low");
  pg_off_a: assert property (
    !power_good |=> !gate_en_u && !gate_en_r) else $error("gate on, pg low");
  permit_only_a: assert property (
    gate_en_u |-> $past(gate_permit_u)) else $error("gate u without permit");
  arm_sticky_a: assert property (
    short_detect_en |=> short_detect_en) else $error("arming dropped");
  sc_all_a: assert property (
    (short_fault_reaction == 3'h4 && short_flag[0]) [*2] |-> !gate_en_v)
    else $error("v gate on in all-phase hold");
  sc_pump_a: assert property (
    (short_detect_en && short_fault_reaction == 3'h5
      && short_detect[0]) [*5]
    |-> charge_pump_off && !diag_ok_n_out) else $error("pump on in short");
  flag_diag_a: assert property (
    short_flag != 3'h0 || low_freq_flag || high_freq_flag
    |=> !diag_ok_n_out) else $error("diag high with a flag");
  mode_freeze_a: assert property (
    (low_freq_flag || high_freq_flag) [*2] |-> $stable(freq_mode))
    else $error("mode changed during fault");
  freq_hold_a: assert property (
    (freq_mode == 3'h3 && low_freq_flag) [*2] |-> !gate_en_r
    && charge_pump_off) else $error("gates on in held freq mode");
  no_detect_a: assert property (
    freq_mode[2] && !low_freq_flag |=> !low_freq_flag)
    else $error("freq fault while off");
  cover property ($rose(short_detect_en));
  cover property (low_freq_flag && freq_mode == 3'h3);
  cover property (high_freq_flag);
endmodule
bind frge_top frge_top_sva chk (.clk_sys, .rst, .alarm_in_a, .alarm_in_b,
  .power_good, .gate_permit_u, .short_detect, .short_fault_reaction,
  .gate_en_u, .gate_en_v, .gate_en_r, .charge_pump_off, .diag_ok_n_out,
  .short_detect_en, .short_flag, .low_freq_flag, .high_freq_flag,
  .freq_mode);

// ==== tb/frge_host_model.sv ====
// Purpose: host side: alarm pins and the free-running reference clock
// Assumes: high and low times of the reference in ns, set by the bench
// Notes: a skewed ratio stands in for a drifting oscillator
`timescale 1ns/1ps
module frge_host_model (
  input int hi_ns, // reference high time
  input int lo_ns, // reference low time
  input logic alm_low_a, // request pin a low
  input logic alm_low_b, // request pin b low
  output logic alarm_in_a, // alarm pin a
  output logic alarm_in_b, // alarm pin b
  output logic ref_clock_1mhz // reference to the device
);
  assign alarm_in_a = !alm_low_a;
  assign alarm_in_b = !alm_low_b;
  // times are re-read each phase so a change lands mid-run
  initial begin
    ref_clock_1mhz = 1'b0;
    forever begin
      #(lo_ns * 1ns) ref_clock_1mhz = 1'b1;
      #(hi_ns * 1ns) ref_clock_1mhz = 1'b0;
    end
  end
endmodule

// ==== tb/fault_reaction_gate_enable_bench.sv ====
// Purpose: self-checking bench for the fault reaction gate block
// Assumes: filter code 0 except one glitch test, so alarms settle in 260
// Notes: expectations come from integer reaction tables below
`timescale 1ns/1ps
module fault_reaction_gate_enable_bench;
  logic clk_sys = 0, rst = 1, power_good = 1, alm_low_a = 0, alm_low_b = 0;
  logic gate_permit_u = 1, gate_permit_v = 1, gate_permit_w = 1;
  logic gate_permit_r = 1, short_flag_clear = 0, freq_flag_clear = 0;
  logic [1:0] alarm_filter_sel = 2'h0;
  logic [2:0] short_detect = 3'h0, short_fault_reaction = 3'h0;
  logic [2:0] freq_fault_reaction = 3'h0, short_flag, freq_mode;
  logic alarm_in_a, alarm_in_b, ref_clock_1mhz, gate_en_u, gate_en_v;
  logic gate_en_w, gate_en_r, charge_pump_off, diag_ok_n_out;
  logic short_detect_en, low_freq_flag, high_freq_flag;
  logic [31:0] seed = 32'h0000ABB2;
  int hi_ns = 500, lo_ns = 500, error_cnt = 0, comparisons = 0, m;
  int md[$] = '{3, 1, 2, 0, 4, 0};
  always #2 clk_sys = !clk_sys;
  frge_top uut (.*);
  frge_host_model host (.*);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic end_of_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [2:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // pulse one clear line for a single cycle
  task automatic clr(input bit fr);
    @(posedge clk_sys);
    if (fr) freq_flag_clear <= 1;
    else short_flag_clear <= 1;
    @(posedge clk_sys);
    {freq_flag_clear, short_flag_clear} <= 2'h0;
    tick(6);
  endtask
  // bounded wait for the relay gate to come up
  task automatic wait_on;
    int i;
    for (i = 0; i < 3000 && gate_en_r !== 1'b1; i++) tick(1);
    if (i == 3000) begin
      error_cnt++;
      end_of_test();
    end
  endtask
  initial begin
    tick(2);
    chk("diag in reset", 0, diag_ok_n_out);
    chk("mode in reset", 0, freq_mode);
    @(posedge clk_sys) rst <= 0;
    wait_on();
    chk("diag idle", 1, diag_ok_n_out);
    repeat (24) begin
      seed = xs(seed);
      @(posedge clk_sys);
      {gate_permit_r, gate_permit_w, gate_permit_v,
        gate_permit_u} <= seed[3:0];
      power_good <= seed[4] | seed[5];
      tick(2);
      chk("gates uvw", {3{power_good}} & {gate_permit_w, gate_permit_v,
        gate_permit_u}, {gate_en_w, gate_en_v, gate_en_u});
      chk("gate r", power_good & gate_permit_r, gate_en_r);
    end
    @(posedge clk_sys);
    {power_good, gate_permit_u, gate_permit_v, gate_permit_w} <= 4'hF;
    gate_permit_r <= 1;
    alm_low_b <= 1;
    repeat (100) @(posedge clk_sys);
    alm_low_b <= 0;
    tick(10);
    chk("glitch ignored", 1, gate_en_u);
    chk("not armed", 0, short_detect_en);
    // a pulse that the shortest filter passes must not pass the next one
    @(posedge clk_sys);
    alarm_filter_sel <= 2'h1;
    alm_low_b <= 1;
    repeat (300) @(posedge clk_sys);
    alm_low_b <= 0;
    tick(10);
    chk("long glitch", 1, gate_en_u);
    @(posedge clk_sys);
    alarm_filter_sel <= 2'h0;
    alm_low_a <= 1;
    tick(300);
    chk("alarm gates", 0, {gate_en_u, gate_en_w, gate_en_r});
    chk("armed", 1, short_detect_en);
    @(posedge clk_sys) alm_low_a <= 0;
    wait_on();
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_sys);
      short_fault_reaction <= 3'(c);
      short_detect <= 3'h1;
      tick(8);
      clr(0);
      chk("flag kept", 1, short_flag);
      chk("phase u", !(c inside {[1:6]}), gate_en_u);
      chk("phase v", !(c inside {[3:6]}), gate_en_v);
      chk("pump", c inside {5, 6}, charge_pump_off);
      chk("short diag", 0, diag_ok_n_out);
      @(posedge clk_sys) short_detect <= 3'h0;
      tick(8);
      chk("held u", !(c inside {2, 4, 6}), gate_en_u);
      chk("held diag", 0, diag_ok_n_out);
      clr(0);
      chk("cleared", {1'b1, 2'h0}, {diag_ok_n_out, short_flag[1:0]});
    end
    @(posedge clk_sys) freq_fault_reaction <= 3'h3;
    tick(10);
    for (int i = 0; i < 5; i++) begin
      m = md[i];
      chk("mode", 3'(m), freq_mode);
      {hi_ns, lo_ns} = {32'd300, 32'd300};
      tick(600);
      chk("low flag", m < 4, low_freq_flag);
      chk("freq relay", m == 0 || m > 3, gate_en_r);
      chk("freq pump", m inside {2, 3}, charge_pump_off);
      // let the fast phases run out first, so a mode that takes effect
      // at once never meets a stale short reference period
      {hi_ns, lo_ns} = {32'd500, 32'd500};
      tick(250);
      @(posedge clk_sys) freq_fault_reaction <= 3'(md[i + 1]);
      tick(4);
      chk("mode frozen", 3'(m < 4 ? m : md[i + 1]), freq_mode);
      tick(750);
      chk("after relay", m != 3, gate_en_r);
      chk("after diag", m > 3, diag_ok_n_out);
      clr(1);
      chk("freq clear", 3'h4, {diag_ok_n_out, low_freq_flag,
        high_freq_flag});
    end
    {hi_ns, lo_ns} = {32'd700, 32'd300};
    tick(1000);
    chk("high flag", 1, high_freq_flag);
    chk("diag only", 1, gate_en_u);
    {hi_ns, lo_ns} = {32'd500, 32'd500};
    tick(1000);
    clr(1);
    chk("high clear", 3'h4, {diag_ok_n_out, low_freq_flag,
      high_freq_flag});
    end_of_test();
  end
endmodule
